/* File: hw/uotg_pkg.sv */
// package for the otg role and vbus status block
package uotg_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG2 = 8'h04;
  localparam logic [7:0] OFF_STAT = 8'h08;
  localparam logic [7:0] OFF_BDTP = 8'h0c;
  localparam logic [7:0] OFF_FRML = 8'h10;
  localparam logic [7:0] OFF_FRMH = 8'h14;
  localparam logic [7:0] OFF_PWM = 8'h18;
  localparam logic [7:0] OFF_HNP = 8'h1c;
  // control register bit positions
  localparam int CTRL_DPPU = 7;
  localparam int CTRL_DMPU = 6;
  localparam int CTRL_DPPD = 5;
  localparam int CTRL_DMPD = 4;
  localparam int CTRL_VBON = 3;
  localparam int CTRL_OTGON = 2;
  // config two bit positions
  localparam int CFG2_SEL = 5;
  localparam int CFG2_DIS = 1;
  // hnp control bit positions
  localparam int HNP_ENABLED = 0;
  localparam int HNP_GRANT = 1;
  localparam int HNP_HOSTEN = 2;
  localparam int HNP_USBEN = 3;
  // status bit positions
  localparam int ST_ID = 7;
  localparam int ST_LSTABLE = 5;
  localparam int ST_SESVLD = 3;
  localparam int ST_B_SESSION_OVER_FLAG = 2;
  localparam int ST_VBVLD = 0;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] CFG2_RST = 8'h00;
  localparam logic [7:0] BDTP_RST = 8'h00;
  localparam logic [15:0] PWM_RST = 16'h0000;
  // timing
  localparam int CLK_MHZ = 200;
  localparam int STABLE_US = 1000;
  localparam int SUSPEND_US = 3000;
  localparam int STABLE_CYC = STABLE_US * CLK_MHZ;
  localparam int SUSPEND_CYC = SUSPEND_US * CLK_MHZ;
  // role negotiation states
  typedef enum logic [2:0] {
    UOTG_HOST = 3'b000,
    UOTG_WAIT_DISC = 3'b001,
    UOTG_PERIPH = 3'b010,
    UOTG_WAIT_ATT = 3'b011,
    UOTG_RESET_BUS = 3'b100
  } uotg_role_t;
  // external comparator inputs
  typedef struct packed {
    logic cmp_a;
    logic cmp_b;
    logic vbus_valid;
    logic sess_valid;
    logic sess_end;
  } uotg_cmp_t;
  // decoded vbus level
  typedef struct packed {
    logic sess_valid;
    logic sess_end;
    logic vbus_valid;
  } uotg_vbus_t;
endpackage

/* File: hw/uotg_top.sv */
// otg role negotiation, vbus status and data registers
// Function
// RULE1: negotiation only after the a-device enables the b-device for it
// RULE2: negotiation starts only while the link runs at full speed
// RULE3: enabled b-device signals disconnect during suspend by dropping pull-ups
// RULE4: a-device sees bus reset flag and may connect as full-speed function
// RULE5: resume instead of connecting keeps the host role, swap abandoned
// RULE6: b-device on attach becomes host and drives bus reset first
// RULE7: b-device finishing as host stops traffic then enables d+ pull-up
// RULE8: a-device on 3 ms idle drops d+ pull-up, may end vbus
// RULE9: a-device on attach resumes host and drives bus reset
// RULE10: external comparator enable bypasses internal vbus comparators
// RULE11: select bit chooses two-pin pair or three-pin external inputs
// RULE12: three-pin decode of session valid and session end levels
// RULE13: registers except pwm implement only the low byte, upper reads zero
// RULE14: descriptor page is 8 bits with bit 0 fixed at zero
// RULE15: frame low and high give an 11-bit frame count
// RULE16: pwm register holds duty in upper byte, period in lower byte
// RULE17: status bit 7 follows the id pin
// RULE18: status bit 5 set when line state stable for previous 1 ms
// RULE19: status bit 3 shows vbus above session valid
// RULE20: status bit 2 shows vbus below b session end
// RULE21: status bit 0 shows vbus above a vbus valid
// RULE22: otg enable hands pulls to software, else host and module enables; with otg enable the PERIPH role also sets the d+ pull-up
// RULE23: external comparator inputs and id pin pass two synchroniser stages
// RULE24: status bits reset to zero, hardware updated, writes ignored
`timescale 1ns/10ps
`default_nettype none
module uotg_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire uotg_pkg::uotg_cmp_t ext_cmp,
  input wire logic id_pin,
  input wire logic int_sess_valid,
  input wire logic int_sess_end,
  input wire logic int_vbus_valid,
  input wire logic line_se0,
  input wire logic line_jstate,
  input wire logic link_full_speed,
  input wire logic bus_reset_irq_flag,
  input wire logic attach_irq_flag,
  input wire logic sof_tick,
  output logic dplus_pullup_enable,
  output logic dminus_pullup_enable,
  output logic dplus_pulldown_enable,
  output logic dminus_pulldown_enable,
  output logic vbus_power_on,
  output logic drive_bus_reset,
  output logic drive_resume,
  output logic is_host
);
  logic [7:0] ctrl;
  logic [7:0] cfg2;
  logic [7:0] hnp;
  logic [7:0] bdtp;
  logic [15:0] pwm;
  logic [10:0] frame;
  logic [7:0] status;
  logic [7:0] next_status;
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [27:0] stable_cnt;
  logic [27:0] idle_cnt;
  logic [1:0] line_prev;
  logic line_stable;
  logic idle_done;
  logic hnp_dp;
  uotg_pkg::uotg_role_t role;
  uotg_pkg::uotg_role_t next_role;
  uotg_pkg::uotg_vbus_t ext_lvl;
  uotg_pkg::uotg_vbus_t lvl;
  logic req;
  logic wr;
  logic hit;
  logic [31:0] rdata;

  // byte lane write merge
  function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
                                      input logic en);
    lane = en ? nw : old;
  endfunction

  // two-stage synchroniser for pins
  // bits: 8 cmp_a, 7 cmp_b, 6 vbus valid, 5 sess valid, 4 sess end, 3 id, 2 se0, 1 j, 0 bus reset
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {ext_cmp, id_pin, line_se0, line_jstate, bus_reset_irq_flag}; // RULE23
      sync2 <= sync1;
    end
  end

  // external comparator decode
  always_comb begin
    if (cfg2[uotg_pkg::CFG2_SEL]) begin // RULE11
      ext_lvl.sess_valid = sync2[5]; // RULE12
      ext_lvl.sess_end = sync2[4] & ~sync2[5];
      ext_lvl.vbus_valid = sync2[6];
    end else begin
      ext_lvl.sess_valid = sync2[7];
      ext_lvl.sess_end = ~sync2[8] & ~sync2[7];
      ext_lvl.vbus_valid = sync2[8] & sync2[7];
    end
  end

  // source select: internal or external comparators
  always_comb begin
    if (cfg2[uotg_pkg::CFG2_DIS]) begin // RULE10
      lvl = ext_lvl;
    end else begin
      lvl.sess_valid = int_sess_valid;
      lvl.sess_end = int_sess_end;
      lvl.vbus_valid = int_vbus_valid;
    end
  end

  // line stable timer over se0 and j state
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      stable_cnt <= 28'h0000000;
      line_prev <= 2'h0;
    end else begin
      line_prev <= sync2[2:1];
      if (line_prev != sync2[2:1]) begin
        stable_cnt <= 28'h0000000; // RULE18
      end else if (stable_cnt < 28'(uotg_pkg::STABLE_CYC)) begin
        stable_cnt <= stable_cnt + 28'h0000001;
      end
    end
  end
  assign line_stable = (stable_cnt >= 28'(uotg_pkg::STABLE_CYC)) && (line_prev == sync2[2:1]);

  // idle timer: j state with no change, used for suspend
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_cnt <= 28'h0000000;
    end else if (!sync2[1] || sync2[2] || line_prev != sync2[2:1]) begin
      idle_cnt <= 28'h0000000;
    end else if (idle_cnt < 28'(uotg_pkg::SUSPEND_CYC)) begin
      idle_cnt <= idle_cnt + 28'h0000001;
    end
  end
  assign idle_done = idle_cnt >= 28'(uotg_pkg::SUSPEND_CYC);

  // status register, hardware driven only
  always_comb begin
    next_status = 8'h00;
    next_status[uotg_pkg::ST_ID] = sync2[3]; // RULE17
    next_status[uotg_pkg::ST_LSTABLE] = line_stable;
    next_status[uotg_pkg::ST_SESVLD] = lvl.sess_valid; // RULE19
    next_status[uotg_pkg::ST_B_SESSION_OVER_FLAG] = lvl.sess_end; // RULE20
    next_status[uotg_pkg::ST_VBVLD] = lvl.vbus_valid; // RULE21
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      status <= 8'h00; // RULE24
    end else begin
      status <= next_status;
    end
  end

  // frame counter, advanced per start of frame
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      frame <= 11'h000;
    end else if (sof_tick) begin
      frame <= frame + 11'h001; // RULE15
    end
  end

  // role state register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      role <= uotg_pkg::UOTG_HOST;
    end else begin
      role <= next_role;
    end
  end

  // host negotiation sequence for the a-device
  always_comb begin
    next_role = role;
    case (role)
      uotg_pkg::UOTG_HOST: begin
        if (hnp[uotg_pkg::HNP_ENABLED] && link_full_speed) begin // RULE1 RULE2
          next_role = uotg_pkg::UOTG_WAIT_DISC;
        end
      end
      uotg_pkg::UOTG_WAIT_DISC: begin
        if (!hnp[uotg_pkg::HNP_ENABLED] || !link_full_speed) begin
          next_role = uotg_pkg::UOTG_HOST;
        end else if (sync2[0]) begin // RULE3
          if (hnp[uotg_pkg::HNP_GRANT]) begin
            next_role = uotg_pkg::UOTG_PERIPH; // RULE4
          end else begin
            next_role = uotg_pkg::UOTG_HOST; // RULE5
          end
        end
      end
      uotg_pkg::UOTG_PERIPH: begin
        if (idle_done) begin
          next_role = uotg_pkg::UOTG_WAIT_ATT; // RULE7 RULE8
        end
      end
      uotg_pkg::UOTG_WAIT_ATT: begin
        if (attach_irq_flag) begin
          next_role = uotg_pkg::UOTG_RESET_BUS; // RULE9
        end
      end
      uotg_pkg::UOTG_RESET_BUS: begin
        if (sync2[0]) begin
          next_role = uotg_pkg::UOTG_HOST;
        end
      end
      default: next_role = uotg_pkg::UOTG_HOST;
    endcase
  end

  // role outputs
  assign hnp_dp = (role == uotg_pkg::UOTG_PERIPH); // RULE4
  assign drive_resume = (role == uotg_pkg::UOTG_WAIT_DISC) && sync2[0] &&
                        !hnp[uotg_pkg::HNP_GRANT]; // RULE5
  assign drive_bus_reset = (role == uotg_pkg::UOTG_RESET_BUS); // RULE9
  assign is_host = (role != uotg_pkg::UOTG_PERIPH) && (role != uotg_pkg::UOTG_WAIT_ATT);
  assign vbus_power_on = ctrl[uotg_pkg::CTRL_VBON];

  // pull resistor control
  always_comb begin
    if (ctrl[uotg_pkg::CTRL_OTGON]) begin // RULE22
      dplus_pullup_enable = ctrl[uotg_pkg::CTRL_DPPU] | hnp_dp;
      dminus_pullup_enable = ctrl[uotg_pkg::CTRL_DMPU];
      dplus_pulldown_enable = ctrl[uotg_pkg::CTRL_DPPD];
      dminus_pulldown_enable = ctrl[uotg_pkg::CTRL_DMPD];
    end else begin
      dplus_pullup_enable = hnp[uotg_pkg::HNP_USBEN] & ~hnp[uotg_pkg::HNP_HOSTEN];
      dminus_pullup_enable = 1'b0;
      dplus_pulldown_enable = hnp[uotg_pkg::HNP_HOSTEN];
      dminus_pulldown_enable = hnp[uotg_pkg::HNP_HOSTEN];
    end
  end

  // wishbone decode
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign wr = req & wb_we_i;
  always_comb begin
    hit = 1'b1;
    rdata = 32'h00000000;
    case (wb_adr_i)
      uotg_pkg::OFF_CTRL: rdata[7:0] = ctrl; // RULE13
      uotg_pkg::OFF_CFG2: rdata[7:0] = cfg2;
      uotg_pkg::OFF_STAT: rdata[7:0] = status;
      uotg_pkg::OFF_BDTP: rdata[7:0] = bdtp;
      uotg_pkg::OFF_FRML: rdata[7:0] = frame[7:0];
      uotg_pkg::OFF_FRMH: rdata[7:0] = {5'h00, frame[10:8]};
      uotg_pkg::OFF_PWM: rdata[15:0] = pwm;
      uotg_pkg::OFF_HNP: rdata[7:0] = hnp;
      default: hit = 1'b0;
    endcase
  end

  // bus answer, one cycle after request
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req & hit;
      wb_err_o <= req & ~hit;
      wb_dat_o <= (req & hit & ~wb_we_i) ? rdata : 32'h00000000;
    end
  end

  // software registers; status and frame ignore writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrl <= uotg_pkg::CTRL_RST;
      cfg2 <= uotg_pkg::CFG2_RST;
      bdtp <= uotg_pkg::BDTP_RST;
      pwm <= uotg_pkg::PWM_RST;
      hnp <= 8'h00;
    end else if (wr) begin
      case (wb_adr_i)
        uotg_pkg::OFF_CTRL: ctrl <= lane(ctrl, wb_dat_i[7:0], wb_sel_i[0]);
        uotg_pkg::OFF_CFG2: cfg2 <= lane(cfg2, wb_dat_i[7:0] & 8'h22, wb_sel_i[0]);
        uotg_pkg::OFF_BDTP: bdtp <= lane(bdtp, wb_dat_i[7:0] & 8'hfe, wb_sel_i[0]); // RULE14
        uotg_pkg::OFF_PWM: begin
          pwm[15:8] <= lane(pwm[15:8], wb_dat_i[15:8], wb_sel_i[1]); // RULE16
          pwm[7:0] <= lane(pwm[7:0], wb_dat_i[7:0], wb_sel_i[0]);
        end
        uotg_pkg::OFF_HNP: hnp <= lane(hnp, wb_dat_i[7:0] & 8'h0f, wb_sel_i[0]);
        default: ctrl <= ctrl;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: testbench/uotg_chk_sva.sv */
// assertion checker for the otg role and vbus status block
`timescale 1ns/10ps
`default_nettype none
module uotg_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic attach_irq_flag,
  input wire logic vbus_power_on,
  input wire logic drive_bus_reset,
  input wire logic drive_resume,
  input wire logic is_host
);
  logic tk;
  logic rd;
  // request about to be taken, and its read flavour
  assign tk = wb_cyc_i & wb_stb_i & !wb_ack_o & !wb_err_o;
  assign rd = tk & !wb_we_i;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  property p_answer; tk |=> wb_ack_o ^ wb_err_o; endproperty
  a_answer: assert property (p_answer) else $error("no single answer");
  property p_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_pulse: assert property (p_pulse) else $error("ack longer than one cycle");
  property p_upper; rd & wb_adr_i != uotg_pkg::OFF_PWM |=> wb_dat_o[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper) else $error("upper byte not zero");
  property p_page; rd & wb_adr_i == uotg_pkg::OFF_BDTP |=> !wb_dat_o[0]; endproperty
  a_page: assert property (p_page) else $error("page bit 0 set");
  property p_frame; rd & wb_adr_i == uotg_pkg::OFF_FRMH |=> wb_dat_o[7:3] == 5'h0; endproperty
  a_frame: assert property (p_frame) else $error("frame high too wide");
  property p_vbus;
    tk & wb_we_i & wb_sel_i[0] & wb_adr_i == uotg_pkg::OFF_CTRL |=>
      vbus_power_on == $past(wb_dat_i[uotg_pkg::CTRL_VBON]);
  endproperty
  a_vbus: assert property (p_vbus) else $error("vbus power not from write");
  property p_resume; drive_resume |-> is_host; endproperty
  a_resume: assert property (p_resume) else $error("resume without host role");
  property p_busrst; $rose(drive_bus_reset) |-> $past(attach_irq_flag); endproperty
  a_busrst: assert property (p_busrst) else $error("bus reset without attach");
endmodule
bind uotg_top uotg_chk i_chk (.*);
`default_nettype wire

/* File: testbench/uotg_peer.sv */
// far-side dual-role device model
`timescale 1ns/10ps
`default_nettype none
module uotg_peer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic swap_req,
  input wire logic low_speed,
  input wire logic dp_pu,
  output logic se0,
  output logic jst,
  output logic fs,
  output logic rst_flag
);
  logic b_pu;
  logic b_host;
  logic [3:0] host_cnt;
  // b side drops its pull-up, takes a short host turn, then connects again
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      b_pu <= 1'b1;
      b_host <= 1'b0;
      host_cnt <= 4'h0;
    end else if (b_host) begin
      host_cnt <= host_cnt + 4'h1;
      if (host_cnt == 4'he) begin
        b_host <= 1'b0;
        b_pu <= 1'b1;
      end
    end else if (swap_req && b_pu && host_cnt == 4'h0) begin
      b_pu <= 1'b0;
    end else if (!b_pu && dp_pu) begin
      b_host <= 1'b1;
    end
  end
  // line levels: bus reset while b is host, else from both pull-ups
  assign se0 = b_host | (!b_pu & !dp_pu);
  assign jst = !b_host & (b_pu | dp_pu);
  assign fs = !low_speed;
  assign rst_flag = se0;
endmodule
`default_nettype wire

/* File: testbench/uotg_top_tb.sv */
// self-checking bench for the otg role and vbus status block
`timescale 1ns/10ps
`default_nettype none
module uotg_top_tb;
  logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, err, swap, ls;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  uotg_pkg::uotg_cmp_t ext_cmp;
  logic id_pin, int_sess_valid, int_sess_end, int_vbus_valid, line_se0, line_jstate;
  logic link_full_speed, bus_reset_irq_flag, attach_irq_flag, sof_tick, dplus_pullup_enable;
  logic dminus_pullup_enable, dplus_pulldown_enable, dminus_pulldown_enable, vbus_power_on;
  logic drive_bus_reset, drive_resume, is_host;
  logic [15:0] v;
  logic [7:0] tbl [3][3] = '{'{8'h08, 8'h00, 8'h08}, '{8'h04, 8'h00, 8'h03}, '{8'h04, 8'h9c, 8'h19}};
  int mismatches, n_compared, k;
  uotg_top i_dut (.*);
  uotg_peer i_peer (.sys_clk(sys_clk), .rst(rst), .swap_req(swap), .low_speed(ls),
    .dp_pu(dplus_pullup_enable),
    .se0(line_se0), .jst(line_jstate), .fs(link_full_speed), .rst_flag(bus_reset_irq_flag));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait for d+ pull-up (0) or resume (1) to go high
  task automatic wait_sig(input int which);
    int n;
    n = 0;
    while ((which == 0 ? dplus_pullup_enable : drive_resume) !== 1'b1 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= 60) begin
      mismatches++;
      complete_run();
    end
  endtask
  // one classic wishbone cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    // hold the request until an answer is sampled at a rising edge
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 60);
    if (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rd = wb_dat_o;
    err = wb_err_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  // expected status from mode, pins and internal levels
  function automatic logic [31:0] stat_exp(input int m, input uotg_pkg::uotg_cmp_t c,
      input logic idp, input logic [2:0] in);
    logic [2:0] s;
    s = m == 0 ? in : m == 1 ? {c.cmp_b, !c.cmp_a & !c.cmp_b, c.cmp_a & c.cmp_b} :
        {c.sess_valid, c.sess_end, c.vbus_valid};
    stat_exp = '0;
    stat_exp[uotg_pkg::ST_ID] = idp;
    stat_exp[uotg_pkg::ST_SESVLD] = s[2];
    stat_exp[uotg_pkg::ST_B_SESSION_OVER_FLAG] = s[1];
    stat_exp[uotg_pkg::ST_VBVLD] = s[0];
  endfunction
  initial begin
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, swap, sof_tick, id_pin, attach_irq_flag} = 8'h01 << 7;
    {wb_adr_i, wb_sel_i, wb_dat_i, ext_cmp, v} = '0;
    {int_sess_valid, int_sess_end, int_vbus_valid} = 3'h0;
    ls = 1'b0;
    wb_sel_i = 4'hf;
    k = $urandom(32'ha3ce);
    do_reset();
    bus(1'b0, uotg_pkg::OFF_BDTP, 0);
    cmp("bdtp_rst", 32'(uotg_pkg::BDTP_RST), rd);
    k = 2040 + $urandom % 20;
    repeat (k) begin
      @(posedge sys_clk);
      sof_tick <= 1'b1;
      @(posedge sys_clk);
      sof_tick <= 1'b0;
    end
    bus(1'b1, uotg_pkg::OFF_FRML, 32'hff);
    bus(1'b0, uotg_pkg::OFF_FRML, 0);
    cmp("frame_low", {24'h0, 8'(k % 2048)}, rd);
    bus(1'b0, uotg_pkg::OFF_FRMH, 0);
    cmp("frame_high", 32'((k % 2048) >> 8), rd);
    bus(1'b0, 8'h40, 0);
    cmp("unmapped", 32'h1, {31'h0, err});
    for (k = 0; k < 6; k++) begin
      v = k == 0 ? 16'hffff : 16'($urandom);
      bus(1'b1, uotg_pkg::OFF_BDTP, {16'hffff, v});
      bus(1'b0, uotg_pkg::OFF_BDTP, 0);
      cmp("page", {24'h0, v[7:1], 1'b0}, rd);
      bus(1'b1, uotg_pkg::OFF_PWM, {16'hffff, v});
      bus(1'b0, uotg_pkg::OFF_PWM, 0);
      cmp("pwm", {16'h0, v}, rd);
    end
    for (k = 0; k < 12; k++) begin
      bus(1'b1, uotg_pkg::OFF_CFG2, 32'(k % 3 != 0) << uotg_pkg::CFG2_DIS |
          32'(k % 3 == 2) << uotg_pkg::CFG2_SEL);
      v = 16'($urandom);
      ext_cmp <= {v[0] & v[1], v[0], v[2] & v[4], v[2], !v[2] & v[3]};
      {int_sess_valid, int_sess_end, int_vbus_valid} <= {v[5], !v[5] & v[6], v[5] & v[7]};
      id_pin <= v[8];
      repeat (4) @(posedge sys_clk);
      bus(1'b0, uotg_pkg::OFF_STAT, 32'hff);
      cmp("status", stat_exp(k % 3, ext_cmp, id_pin,
          {int_sess_valid, int_sess_end, int_vbus_valid}), rd);
    end
    for (k = 0; k < 3; k++) begin
      bus(1'b1, uotg_pkg::OFF_HNP, 32'(tbl[k][0]));
      bus(1'b1, uotg_pkg::OFF_CTRL, 32'(tbl[k][1]));
      @(posedge sys_clk);
      cmp("pulls", 32'(tbl[k][2]), {27'h0, vbus_power_on, dplus_pullup_enable,
          dminus_pullup_enable, dplus_pulldown_enable, dminus_pulldown_enable});
    end
    bus(1'b1, uotg_pkg::OFF_CTRL, 32'h04);
    bus(1'b1, uotg_pkg::OFF_HNP, 32'h00);
    swap <= 1'b1;
    repeat (10) @(posedge sys_clk);
    cmp("host_kept", 32'h1, {31'h0, is_host});
    ls <= 1'b1;
    bus(1'b1, uotg_pkg::OFF_HNP, 32'h03);
    repeat (10) @(posedge sys_clk);
    cmp("host_kept_ls", 32'h1, {31'h0, is_host});
    ls <= 1'b0;
    wait_sig(0);
    cmp("handover", 32'h1, {31'h0, dplus_pullup_enable & !is_host});
    swap <= 1'b0;
    do_reset();
    bus(1'b1, uotg_pkg::OFF_CTRL, 32'h04);
    bus(1'b1, uotg_pkg::OFF_HNP, 32'h01);
    swap <= 1'b1;
    wait_sig(1);
    cmp("resume_host", 32'h1, {31'h0, is_host});
    complete_run();
  end
endmodule
`default_nettype wire
